//--- rtl/upra_map.svh
// Offsets, field positions and counts of the packet interpreter
`ifndef UPRA_MAP_SVH
`define UPRA_MAP_SVH
`define UPRA_RSVD_BYTE      8'h00
`define UPRA_HDR_BYTES      4'h7
`define UPRA_DIR_BIT        31
`define UPRA_MOD_MSB        30
`define UPRA_MOD_LSB        24
`define UPRA_MOD_CHAIN      7'h01
`define UPRA_MOD_NVMEM      7'h10
`define UPRA_CHAIN_REG_MAX  24'h00001f
`define UPRA_FIFO_DEPTH     32
`endif

//--- rtl/upra_pkg.sv
// Types of the packet interpreter
package upra_pkg;
   typedef enum logic [2:0] {
      UPRA_IDLE,
      UPRA_HDR,
      UPRA_WR_HI,
      UPRA_WR_LO,
      UPRA_WR_ACC,
      UPRA_RD_REQ,
      UPRA_RD_WAIT,
      UPRA_RD_LO
   } upra_state_t;

   typedef struct packed {
      logic        write;
      logic [6:0]  module_num;
      logic [23:0] reg_addr;
   } upra_addr_t;

   typedef struct packed {
      logic        req;
      logic        write;
      logic [4:0]  reg_addr;
      logic [15:0] wdata;
   } upra_chain_req_t;
endpackage

//--- rtl/upra_fifo.sv
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
module upra_fifo
#(
   parameter int WIDTH = 8,
   parameter int DEPTH = 32
)
(
   input  wire logic             mclk_in,
   input  wire logic             reset_n_in,
   input  wire logic             ce_in,
   input  wire logic             in_valid_in,
   output logic                  in_ready_out,
   input  wire logic [WIDTH-1:0] in_data_in,
   output logic                  out_valid_out,
   input  wire logic             out_ready_in,
   output logic      [WIDTH-1:0] out_data_out
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0]    wr_q, wr_d, rd_q, rd_d;
   logic [AW:0]      cnt_q, cnt_d;
   logic             rdy_q, rdy_d;
   logic             push, pop;

   always_comb
   begin
      push = ce_in && in_valid_in && rdy_q;
      pop  = ce_in && out_ready_in && (cnt_q != '0);
      wr_d = push ? wr_q + 1'b1 : wr_q;
      rd_d = pop ? rd_q + 1'b1 : rd_q;
      cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
      // Ready from a flop, so the pin never glitches on the count
      rdy_d = (cnt_d != (AW+1)'(DEPTH));
   end

   always_ff @(posedge mclk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         wr_q  <= '0;
         rd_q  <= '0;
         cnt_q <= '0;
         rdy_q <= 1'b0;
      end
      else
      begin
         wr_q  <= wr_d;
         rd_q  <= rd_d;
         cnt_q <= cnt_d;
         rdy_q <= rdy_d;
      end
   end

   always_ff @(posedge mclk_in)
   begin
      if (push)
      begin
         mem_q[wr_q] <= in_data_in;
      end
   end

   assign in_ready_out  = rdy_q;
   assign out_valid_out = (cnt_q != '0);
   assign out_data_out  = mem_q[rd_q];
endmodule

//--- rtl/upra_top.sv
// Packet interpreter: byte packets to register accesses on the chain module only
`timescale 1ns/1ps
`include "upra_map.svh"
module upra_top
   import upra_pkg::*;
#(
   parameter int FIFO_DEPTH = `UPRA_FIFO_DEPTH
)
(
   input  wire logic         mclk_in,
   input  wire logic         reset_n_in,
   input  wire logic         ce_in,
   input  wire logic         rx_valid_in,
   output logic              rx_ready_out,
   input  wire logic [7:0]   rx_data_in,
   output logic              tx_valid_out,
   input  wire logic         tx_ready_in,
   output logic      [7:0]   tx_data_out,
   output upra_chain_req_t   chain_req_out,
   input  wire logic         chain_ack_in,
   input  wire logic [15:0]  chain_rdata_in
);

   // ==========================================================
   // Receive buffer
   logic       fifo_valid, fifo_ready, fifo_in_ready;
   logic [7:0] fifo_data;

   upra_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_rx_fifo
   (
      .mclk_in       (mclk_in),
      .reset_n_in    (reset_n_in),
      .ce_in         (ce_in),
      .in_valid_in   (rx_valid_in),
      .in_ready_out  (fifo_in_ready),
      .in_data_in    (rx_data_in),
      .out_valid_out (fifo_valid),
      .out_ready_in  (fifo_ready),
      .out_data_out  (fifo_data)
   );

   // ==========================================================
   // Packet state
   upra_state_t     st_q, st_d;
   logic [55:0]     hdr_q, hdr_d;
   logic [3:0]      hcnt_q, hcnt_d;
   logic [23:0]     words_q, words_d;
   upra_addr_t      addr_q, addr_d;
   logic [15:0]     wbuf_q, wbuf_d;
   upra_chain_req_t req_q, req_d;
   logic            txv_q, txv_d;
   logic [7:0]      txd_q, txd_d;
   logic            tx_free, hit_chain;

   always_comb
   begin
      tx_free   = !txv_q || tx_ready_in;
      hit_chain = (addr_q.module_num == `UPRA_MOD_CHAIN) &&
                  (addr_q.reg_addr <= `UPRA_CHAIN_REG_MAX);
      st_d      = st_q;
      hdr_d     = hdr_q;
      hcnt_d    = hcnt_q;
      words_d   = words_q;
      addr_d    = addr_q;
      wbuf_d    = wbuf_q;
      req_d     = req_q;
      req_d.req = 1'b0;
      txv_d     = txv_q && !tx_ready_in;
      txd_d     = txd_q;
      fifo_ready = 1'b0;
      unique case (st_q)
         UPRA_IDLE:
         begin
            fifo_ready = 1'b1;
            if (fifo_valid && fifo_data == `UPRA_RSVD_BYTE)
            begin
               hcnt_d = '0;
               st_d   = UPRA_HDR;
            end
         end
         UPRA_HDR:
         begin
            fifo_ready = 1'b1;
            if (fifo_valid)
            begin
               hdr_d  = {hdr_q[47:0], fifo_data};
               hcnt_d = hcnt_q + 4'h1;
               if (hcnt_q == `UPRA_HDR_BYTES - 4'h1)
               begin
                  addr_d.write      = hdr_d[24 + `UPRA_DIR_BIT];
                  addr_d.module_num = hdr_d[24 + `UPRA_MOD_MSB:24 + `UPRA_MOD_LSB];
                  addr_d.reg_addr   = hdr_d[47:24];
                  words_d = hdr_d[23:0];
                  if (hdr_d[23:0] == 24'h000000)
                     st_d = UPRA_IDLE;
                  else if (hdr_d[24 + `UPRA_DIR_BIT])
                     st_d = UPRA_WR_HI;
                  else
                     st_d = UPRA_RD_REQ;
               end
            end
         end
         UPRA_WR_HI:
         begin
            fifo_ready = 1'b1;
            if (fifo_valid)
            begin
               wbuf_d[15:8] = fifo_data;
               st_d = UPRA_WR_LO;
            end
         end
         UPRA_WR_LO:
         begin
            fifo_ready = 1'b1;
            if (fifo_valid)
            begin
               wbuf_d[7:0] = fifo_data;
               st_d = UPRA_WR_ACC;
               if (hit_chain)
               begin
                  req_d.req      = 1'b1;
                  req_d.write    = 1'b1;
                  req_d.reg_addr = addr_q.reg_addr[4:0];
                  req_d.wdata    = {wbuf_q[15:8], fifo_data};
               end
            end
         end
         UPRA_WR_ACC:
         begin
            if (chain_ack_in || !hit_chain)
            begin
               addr_d.reg_addr = addr_q.reg_addr + 24'h000001;
               words_d = words_q - 24'h000001;
               st_d = (words_q == 24'h000001) ? UPRA_IDLE : UPRA_WR_HI;
            end
         end
         UPRA_RD_REQ:
         begin
            if (tx_free)
            begin
               st_d = UPRA_RD_WAIT;
               if (hit_chain)
               begin
                  req_d.req      = 1'b1;
                  req_d.write    = 1'b0;
                  req_d.reg_addr = addr_q.reg_addr[4:0];
               end
            end
         end
         UPRA_RD_WAIT:
         begin
            if ((chain_ack_in || !hit_chain) && tx_free)
            begin
               wbuf_d = hit_chain ? chain_rdata_in : 16'h0000;
               txv_d  = 1'b1;
               txd_d  = wbuf_d[15:8];
               st_d   = UPRA_RD_LO;
            end
         end
         UPRA_RD_LO:
         begin
            if (tx_free)
            begin
               txv_d = 1'b1;
               txd_d = wbuf_q[7:0];
               addr_d.reg_addr = addr_q.reg_addr + 24'h000001;
               words_d = words_q - 24'h000001;
               st_d = (words_q == 24'h000001) ? UPRA_IDLE : UPRA_RD_REQ;
            end
         end
      endcase
      if (!ce_in)
      begin
         fifo_ready = 1'b0;
      end
   end

   always_ff @(posedge mclk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         st_q    <= UPRA_IDLE;
         hdr_q   <= '0;
         hcnt_q  <= '0;
         words_q <= '0;
         addr_q  <= '0;
         wbuf_q  <= '0;
         req_q   <= '0;
         txv_q   <= 1'b0;
         txd_q   <= 8'h00;
      end
      else if (ce_in)
      begin
         st_q    <= st_d;
         hdr_q   <= hdr_d;
         hcnt_q  <= hcnt_d;
         words_q <= words_d;
         addr_q  <= addr_d;
         wbuf_q  <= wbuf_d;
         req_q   <= req_d;
         txv_q   <= txv_d;
         txd_q   <= txd_d;
      end
   end

   // Ready is a flop inside the buffer; it already counts the byte in flight
   assign rx_ready_out  = fifo_in_ready;
   assign tx_valid_out  = txv_q;
   assign tx_data_out   = txd_q;
   assign chain_req_out = req_q;

   // ==========================================================
   // Checks
   sequence s_rd_hi;
      st_q == UPRA_RD_WAIT && st_d == UPRA_RD_LO;
   endsequence

   property p_rd_pair;
      @(posedge mclk_in) disable iff (!reset_n_in)
      (s_rd_hi and ce_in) |=> tx_valid_out && st_q == UPRA_RD_LO;
   endproperty
   a_rd_pair: assert property (p_rd_pair) else $error("read word not sent");

   property p_dir;
      @(posedge mclk_in) disable iff (!reset_n_in)
      chain_req_out.req && st_q == UPRA_WR_ACC |-> chain_req_out.write;
   endproperty
   a_dir: assert property (p_dir) else $error("write issued as read");

   property p_route;
      @(posedge mclk_in) disable iff (!reset_n_in)
      chain_req_out.req |-> addr_q.module_num == `UPRA_MOD_CHAIN;
   endproperty
   a_route: assert property (p_route) else $error("chain hit by wrong module");

   sequence s_wr_take;
      st_q == UPRA_WR_LO && fifo_valid && hit_chain;
   endsequence

   sequence s_hdr_last;
      st_q == UPRA_HDR && fifo_valid && hcnt_q == `UPRA_HDR_BYTES - 4'h1;
   endsequence

   property p_wr_issue;
      @(posedge mclk_in) disable iff (!reset_n_in)
      (s_wr_take and ce_in) |=> chain_req_out.req && chain_req_out.write &&
         chain_req_out.wdata[7:0] == $past(fifo_data) &&
         chain_req_out.reg_addr == addr_q.reg_addr[4:0];
   endproperty
   a_wr_issue: assert property (p_wr_issue) else $error("write word not issued");

   property p_req_pulse;
      @(posedge mclk_in) disable iff (!reset_n_in)
      ce_in && chain_req_out.req |=> !chain_req_out.req;
   endproperty
   a_req_pulse: assert property (p_req_pulse) else $error("access request held");

   property p_tx_hold;
      @(posedge mclk_in) disable iff (!reset_n_in)
      tx_valid_out && !tx_ready_in |=> tx_valid_out && $stable(tx_data_out);
   endproperty
   a_tx_hold: assert property (p_tx_hold) else $error("read byte dropped");

   property p_rd_zero;
      @(posedge mclk_in) disable iff (!reset_n_in)
      ce_in && st_q == UPRA_RD_WAIT && !hit_chain |=>
         tx_valid_out && tx_data_out == 8'h00 && st_q == UPRA_RD_LO;
   endproperty
   a_rd_zero: assert property (p_rd_zero) else $error("unmapped read not zero");

   property p_hdr_load;
      @(posedge mclk_in) disable iff (!reset_n_in)
      (s_hdr_last and ce_in) |=> words_q == hdr_q[23:0] &&
         addr_q.module_num == hdr_q[54:48] && addr_q.write == hdr_q[55];
   endproperty
   a_hdr_load: assert property (p_hdr_load) else $error("header fields misloaded");

   property p_len_zero;
      @(posedge mclk_in) disable iff (!reset_n_in)
      (s_hdr_last and ce_in and hdr_d[23:0] == 24'h000000) |=> st_q == UPRA_IDLE;
   endproperty
   a_len_zero: assert property (p_len_zero) else $error("empty packet not ended");
endmodule

//--- test/upra_host_model.sv
// Host side bridge model: byte source and sink
`timescale 1ns/1ps
module upra_host_model
(
   input  wire logic       mclk_in,
   output logic            rx_valid_out,
   input  wire logic       rx_ready_in,
   output logic      [7:0] rx_data_out,
   input  wire logic       tx_valid_in,
   output logic            tx_ready_out,
   input  wire logic [7:0] tx_data_in
);
   logic [7:0] out_q[$];
   logic [7:0] got_q[$];
   bit         slow = 1'b0;
   initial
   begin
      rx_valid_out = 1'b0;
      rx_data_out  = 8'h00;
      tx_ready_out = 1'b0;
   end
   // =====
   // synchronous FIFO handshake
   always @(posedge mclk_in)
   begin
      if (rx_valid_out && rx_ready_in)
         void'(out_q.pop_front());
      if (tx_valid_in && tx_ready_out)
         got_q.push_back(tx_data_in);
      #1;
      rx_valid_out = out_q.size() > 0;
      // Idle data toggles so a stale byte never looks valid
      rx_data_out  = rx_valid_out ? out_q[0] : ~rx_data_out;
      tx_ready_out = slow ? 1'($urandom_range(1)) : 1'b1;
   end
endmodule

//--- test/usb_packet_register_access_tb_top.sv
// Testbench of the packet interpreter
`timescale 1ns/1ps
`include "upra_map.svh"
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin error_cnt++; \
   $display("unexpected at %0t: got %h exp %h", $time, g, e); end end
module usb_packet_register_access_tb_top
   import upra_pkg::*;
;
   logic            mclk_in    = 1'b0;
   logic            reset_n_in = 1'b0;
   logic            ce_in      = 1'b1;
   logic            rx_valid, rx_ready, tx_valid, tx_ready, ack = 1'b0;
   logic [7:0]      rx_data, tx_data;
   logic [15:0]     rdata = 16'h0000;
   upra_chain_req_t req, rq;
   logic [15:0]     chain_mem[32], mirror[32];
   int              error_cnt, cmp_count, nreq, exp_req, dly, cyc;
   bit              pend;

   always #25 mclk_in = ~mclk_in;

   upra_top dut (.mclk_in(mclk_in), .reset_n_in(reset_n_in), .ce_in(ce_in),
      .rx_valid_in(rx_valid), .rx_ready_out(rx_ready), .rx_data_in(rx_data),
      .tx_valid_out(tx_valid), .tx_ready_in(tx_ready), .tx_data_out(tx_data),
      .chain_req_out(req), .chain_ack_in(ack), .chain_rdata_in(rdata));

   upra_host_model host (.mclk_in(mclk_in), .rx_valid_out(rx_valid), .rx_ready_in(rx_ready),
      .rx_data_out(rx_data), .tx_valid_in(tx_valid), .tx_ready_out(tx_ready),
      .tx_data_in(tx_data));

   // =====
   // Chain responder, ack after 0..3 idle cycles
   always @(posedge mclk_in)
   begin
      #1;
      ack   = 1'b0;
      rdata = ~rdata;
      if (req.req === 1'b1)
      begin
         rq   = req;
         pend = 1'b1;
         dly  = $urandom_range(3);
         nreq++;
      end
      else if (pend && dly > 0)
         dly--;
      else if (pend)
      begin
         pend = 1'b0;
         ack  = 1'b1;
         if (rq.write)
            chain_mem[rq.reg_addr] = rq.wdata;
         else
            rdata = chain_mem[rq.reg_addr];
      end
   end

   always @(posedge mclk_in)
   begin
      cyc++;
      if (cyc == 40000)
      begin
         error_cnt++;
         conclude();
      end
   end

   function automatic bit hit(logic [6:0] m, logic [23:0] r);
      return m == `UPRA_MOD_CHAIN && r <= `UPRA_CHAIN_REG_MAX;
   endfunction

   function automatic logic [15:0] exp_word(logic [6:0] m, logic [23:0] r);
      return hit(m, r) ? mirror[r[4:0]] : 16'h0000;
   endfunction

   // =====
   // Writes are queued only; reads wait for everything before them
   task automatic pkt(input logic wr, input logic [6:0] m, input logic [23:0] r,
                      input logic [23:0] n);
      logic [31:0] a;
      logic [15:0] w;
      int          t;
      a = {wr, m, r};
      host.out_q.push_back(`UPRA_RSVD_BYTE);
      for (int i = 3; i >= 0; i--)
         host.out_q.push_back(a[8*i+:8]);
      for (int i = 2; i >= 0; i--)
         host.out_q.push_back(n[8*i+:8]);
      for (int i = 0; i < n; i++)
      begin
         if (hit(m, r + 24'(i)))
            exp_req++;
         if (wr)
         begin
            w = 16'($urandom);
            host.out_q.push_back(w[15:8]);
            host.out_q.push_back(w[7:0]);
            if (hit(m, r + 24'(i)))
               mirror[r[4:0] + 5'(i)] = w;
         end
      end
      if (!wr)
      begin
         t = 0;
         while ((host.out_q.size() != 0 || pend || host.got_q.size() < 2 * n) && t < 5000)
         begin
            @(posedge mclk_in);
            t++;
         end
         repeat (8) @(posedge mclk_in);
         `CHK(host.got_q.size(), 2 * n)
         for (int i = 0; i < n && host.got_q.size() > 1; i++)
         begin
            w[15:8] = host.got_q.pop_front();
            w[7:0]  = host.got_q.pop_front();
            `CHK(w, exp_word(m, r + 24'(i)))
         end
         `CHK(nreq, exp_req)
         host.got_q.delete();
      end
   endtask

   task automatic conclude();
      $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   initial
   begin
      int n;
      int b;
      void'($urandom(51));
      for (int i = 0; i < 32; i++)
      begin
         chain_mem[i] = 16'(i * 3);
         mirror[i]    = 16'(i * 3);
      end
      repeat (4) @(posedge mclk_in);
      `CHK(tx_valid, 1'b0)
      `CHK(req.req, 1'b0)
      #1 reset_n_in = 1'b1;
      repeat (2) @(posedge mclk_in);
      #1;
      pkt(1'b1, `UPRA_MOD_CHAIN, 24'h000005, 24'h000001);
      pkt(1'b0, `UPRA_MOD_CHAIN, 24'h000005, 24'h000001);
      pkt(1'b1, `UPRA_MOD_CHAIN, 24'h00001f, 24'h000001);
      pkt(1'b0, `UPRA_MOD_CHAIN, 24'h00001f, 24'h000001);
      $display("test 1 done");
      host.slow = 1'b1;
      for (int k = 0; k < 8; k++)
      begin
         n = $urandom_range(8, 1);
         b = $urandom_range(32 - n);
         pkt(1'b1, `UPRA_MOD_CHAIN, 24'(b), 24'(n));
         pkt(1'b0, `UPRA_MOD_CHAIN, 24'(b), 24'(n));
      end
      pkt(1'b0, `UPRA_MOD_CHAIN, 24'h000000, 24'h000020);
      $display("test 2 done");
      pkt(1'b1, `UPRA_MOD_NVMEM, 24'h000002, 24'h000002);
      pkt(1'b0, `UPRA_MOD_NVMEM, 24'h000002, 24'h000002);
      pkt(1'b0, 7'h04, 24'h000005, 24'h000001);
      pkt(1'b0, `UPRA_MOD_CHAIN, 24'h000020, 24'h000002);
      $display("test 3 done");
      host.out_q.push_back(8'h55);
      pkt(1'b0, `UPRA_MOD_CHAIN, 24'h000003, 24'h000000);
      pkt(1'b0, `UPRA_MOD_CHAIN, 24'h000003, 24'h000001);
      $display("test 4 done");
      // Enable low while idle: nothing may move
      #1 ce_in = 1'b0;
      repeat (5) @(posedge mclk_in);
      `CHK(tx_valid, 1'b0)
      `CHK(req.req, 1'b0)
      #1 ce_in = 1'b1;
      pkt(1'b0, `UPRA_MOD_CHAIN, 24'h000004, 24'h000002);
      $display("test 5 done");
      conclude();
   end
endmodule
